// >>> core/uart_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef UART_REGS_SVH
`define UART_REGS_SVH

`define ADDR_WIDTH 10
`define ADDR_RX_TX 10'h3f8
`define ADDR_IRQ_EN 10'h3f9
`define ADDR_IRQ_ID 10'h3fa
`define ADDR_LINE_CTRL 10'h3fb
`define ADDR_LINE_STAT 10'h3fd
`define ADDR_MODEM_STAT 10'h3fe

`define LS_RX_READY 0
`define LS_OVERRUN 1
`define LS_PARITY 2
`define LS_FRAMING 3
`define LS_BREAK 4
`define LS_TX_HOLD_EMPTY 5
`define LS_TX_SHIFT_EMPTY 6

`define LC_STOP 2
`define LC_PARITY_EN 3
`define LC_EVEN 4
`define LC_STICK 5
`define LC_SET_BREAK 6
`define LC_DIV_ACCESS 7

`define IE_RX_DATA 0
`define IE_TX_EMPTY 1
`define IE_LINE_STAT 2
`define IE_MODEM 3

`define ID_NONE 3'h1
`define ID_LINE_STAT 3'h6
`define ID_RX_DATA 3'h4
`define ID_TX_EMPTY 3'h2
`define ID_MODEM 3'h0

`define DIVISOR_RESET 16'h000c
`define LINE_CTRL_RESET 8'h00
`define TICK_MID 4'h7
`define TICK_LAST 4'hf
`define TICKS_PER_BIT 8'h10
`define STOP_TICKS_ONE 6'h0f
`define STOP_TICKS_HALF 6'h17
`define STOP_TICKS_TWO 6'h1f

`endif

// >>> core/uart_pkg.sv
// state types shared by the serial controller modules
package uart_pkg;
  typedef enum logic [2:0] {
    rx_idle = 3'h0,
    rx_start = 3'h1,
    rx_data = 3'h3,
    rx_parity = 3'h2,
    rx_stop = 3'h6
  } rx_state_type;

  typedef enum logic [2:0] {
    tx_idle = 3'h0,
    tx_start = 3'h1,
    tx_data = 3'h3,
    tx_parity = 3'h2,
    tx_stop = 3'h6
  } tx_state_type;
endpackage

// >>> core/rx_link_if.sv
// signals between the controller core and its receiver
`timescale 1ns/1ns
`default_nettype none
interface rx_link_if;
  logic tick16;
  logic sin;
  logic [1:0] word_len;
  logic parity_en;
  logic even;
  logic stick;
  logic char_valid;
  logic [7:0] char_data;
  logic parity_err;
  logic framing_err;
  logic break_det;

  modport receiver (
    input tick16, sin, word_len, parity_en, even, stick,
    output char_valid, char_data, parity_err, framing_err, break_det
  );
  modport core (
    output tick16, sin, word_len, parity_en, even, stick,
    input char_valid, char_data, parity_err, framing_err, break_det
  );
endinterface
`default_nettype wire

// >>> core/uart_rx_frame.sv
// serial receiver: start detect, centre sampling, error and break detect
`timescale 1ns/1ns
`default_nettype none
`include "uart_regs.svh"
module uart_rx_frame #(
  parameter int LOW_CNT_WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  rx_link_if.receiver link
);
  typedef struct packed {
    uart_pkg::rx_state_type state;
    logic [3:0] cnt;
    logic [2:0] idx;
    logic [7:0] data;
    logic perr;
    logic [LOW_CNT_WIDTH-1:0] low_cnt;
    logic valid;
    logic [7:0] out_data;
    logic out_perr;
    logic out_ferr;
    logic brk;
  } r_type;

  r_type r_q;
  r_type r_d;
  logic [7:0] mask;
  logic [LOW_CNT_WIDTH-1:0] brk_thr;
  logic expect_par;

  generate
    if (LOW_CNT_WIDTH < 8)
    begin : g_chk
      $error("LOW_CNT_WIDTH too small for a full character time");
    end
  endgenerate

  assign mask = 8'hff >> (2'h3 - link.word_len);
  // one character time: start, 5..8 data, optional parity, one stop
  assign brk_thr = LOW_CNT_WIDTH'(`TICKS_PER_BIT * (8'h07 + 8'(link.word_len)
                   + 8'(link.parity_en)));
  assign expect_par = link.stick ? ~link.even
                    : (^(r_q.data & mask)) ^ ~link.even;

  always_comb
  begin
    r_d = r_q;
    r_d.valid = 1'b0;
    r_d.brk = 1'b0;
    if (link.tick16)
    begin
      // break after a full character time
      if (link.sin)
        r_d.low_cnt = '0;
      else if (r_q.low_cnt != {LOW_CNT_WIDTH{1'b1}})
      begin
        r_d.low_cnt = r_q.low_cnt + 1'b1;
        if (r_q.low_cnt == brk_thr)
          r_d.brk = 1'b1;
      end
      r_d.cnt = r_q.cnt + 4'h1;
      // sample each bit at its centre
      case (r_q.state)
        uart_pkg::rx_idle:
        begin
          r_d.cnt = 4'h0;
          if (!link.sin)
            r_d.state = uart_pkg::rx_start;
        end
        uart_pkg::rx_start:
        begin
          if (r_q.cnt == `TICK_MID)
          begin
            r_d.cnt = 4'h0;
            r_d.idx = 3'h0;
            r_d.data = 8'h00;
            r_d.perr = 1'b0;
            // glitch shorter than half a bit is no start
            r_d.state = link.sin ? uart_pkg::rx_idle : uart_pkg::rx_data;
          end
        end
        uart_pkg::rx_data:
        begin
          if (r_q.cnt == `TICK_LAST)
          begin
            r_d.data[r_q.idx] = link.sin;
            r_d.idx = r_q.idx + 3'h1;
            if (r_q.idx == 3'h4 + {1'b0, link.word_len})
              r_d.state = link.parity_en ? uart_pkg::rx_parity
                        : uart_pkg::rx_stop;
          end
        end
        uart_pkg::rx_parity:
        begin
          if (r_q.cnt == `TICK_LAST)
          begin
            r_d.perr = link.sin != expect_par;
            r_d.state = uart_pkg::rx_stop;
          end
        end
        uart_pkg::rx_stop:
        begin
          if (r_q.cnt == `TICK_LAST)
          begin
            r_d.valid = 1'b1;
            r_d.out_data = r_q.data;
            r_d.out_perr = r_q.perr;
            r_d.out_ferr = ~link.sin;
            r_d.state = uart_pkg::rx_idle;
          end
        end
        default:
          r_d.state = uart_pkg::rx_idle;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      r_q <= '{state: uart_pkg::rx_idle, default: '0};
    else
      r_q <= r_d;
  end

  assign link.char_valid = r_q.valid;
  assign link.char_data = r_q.out_data;
  assign link.parity_err = r_q.out_perr;
  assign link.framing_err = r_q.out_ferr;
  assign link.break_det = r_q.brk;
endmodule
`default_nettype wire

// >>> core/uart_line_status_irq_id.sv
// serial controller: baud divider, transmitter, line status and irq id
//
// Summary of operation
// - 16-bit divisor divides reference clock into 16x bit clock enable.
// - receive ready sets when a whole character lands in buffer.
// - receive ready clears on buffer read or written zero.
// - overrun sets when new character overwrites an unread one.
// - overrun clears on line status read.
// - parity error sets on wrong parity, clears on line status read.
// - framing error sets when stop bit is sampled low.
// - break sets when input stays low over one character time.
// - overrun, parity, framing or break raise line status interrupt.
// - holding empty sets on transfer to shifter, clears on load.
// - holding empty requests interrupt on transfer to shifter when its enable is set.
// - shifter empty is read-only, set while shifter idles.
// - line status bit 7 reads zero.
// - priority: line status, received data, holding empty, modem.
// - addressing identification register freezes the reported source.
// - identification bit 0 low while an interrupt is pending.
// - codes: 001 none, 110 line, 100 data, 010 tx, 000 modem.
// - identification bits 3 to 7 read zero.
// - tx interrupt clears on id read while reported or holding write.
// - data, line and modem interrupts clear on their register reads.
// - modem interrupt comes from a change on cts, dsr or carrier detect, or from ring going inactive.
// - each source gated by enable bits 0 to 3.
// - irq output high while any enabled source is active.
// - after reset identification reads bit 0 high, others low.
`timescale 1ns/1ns
`default_nettype none
`include "uart_regs.svh"
module uart_line_status_irq_id #(
  parameter int DIV_WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cpu_cs,
  input wire logic [9:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic irq_out,
  output logic baud_out,
  input wire logic sin,
  output logic sout,
  input wire logic cts_in_n,
  input wire logic dsr_in_n,
  input wire logic ri_in_n,
  input wire logic carrier_detect_in_n
);
  typedef struct packed {
    logic [15:0] div;
    logic [15:0] bcnt;
    logic tick;
    logic [7:0] lcr;
    logic [3:0] interrupt_enable_mask;
    logic [7:0] rx_buffer;
    logic rx_ready_flag;
    logic overrun_flag;
    logic parity_err_flag;
    logic framing_err_flag;
    logic break_flag;
    logic ls_irq;
    logic tx_holding_empty_irq;
    logic tx_holding_empty;
    logic tx_shifter_empty;
    logic [7:0] tx_holding;
    uart_pkg::tx_state_type tx_state;
    logic [5:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    logic sout;
    logic [3:0] msr_delta;
    logic [3:0] msr_prev;
    logic [2:0] pending_interrupt_code;
    logic irq;
    logic [7:0] rdata;
  } s_type;

  s_type s_q;
  s_type s_d;
  rx_link_if link ();

  logic hit_rxtx;
  logic hit_ier;
  logic hit_iir;
  logic hit_lcr;
  logic hit_lsr;
  logic hit_msr;
  logic rd;
  logic wr;
  logic dlab;
  logic [3:0] modem_now;
  logic [3:0] src;
  logic [7:0] lsr_val;
  logic [7:0] txmask;
  logic [5:0] stop_last;

  generate
    if (DIV_WIDTH != 16)
    begin : g_chk
      $error("divisor latches hold exactly 16 bits");
    end
  endgenerate

  assign hit_rxtx = cpu_addr == `ADDR_RX_TX;
  assign hit_ier = cpu_addr == `ADDR_IRQ_EN;
  assign hit_iir = cpu_addr == `ADDR_IRQ_ID;
  assign hit_lcr = cpu_addr == `ADDR_LINE_CTRL;
  assign hit_lsr = cpu_addr == `ADDR_LINE_STAT;
  assign hit_msr = cpu_addr == `ADDR_MODEM_STAT;
  assign rd = cpu_cs & cpu_rd;
  assign wr = cpu_cs & cpu_wr;
  assign dlab = s_q.lcr[`LC_DIV_ACCESS];
  // status bits are the complement of the active-low pins
  assign modem_now = {~carrier_detect_in_n, ~ri_in_n, ~dsr_in_n, ~cts_in_n};
  assign lsr_val = {1'b0, s_q.tx_shifter_empty, s_q.tx_holding_empty,
                    s_q.break_flag, s_q.framing_err_flag,
                    s_q.parity_err_flag, s_q.overrun_flag,
                    s_q.rx_ready_flag};
  assign txmask = 8'hff >> (2'h3 - s_q.lcr[1:0]);
  // 1.5 stop bits only for 5-bit words
  assign stop_last = !s_q.lcr[`LC_STOP] ? `STOP_TICKS_ONE
                   : (s_q.lcr[1:0] == 2'h0) ? `STOP_TICKS_HALF
                   : `STOP_TICKS_TWO;

  assign link.tick16 = s_q.tick;
  assign link.sin = sin;
  assign link.word_len = s_q.lcr[1:0];
  assign link.parity_en = s_q.lcr[`LC_PARITY_EN];
  assign link.even = s_q.lcr[`LC_EVEN];
  assign link.stick = s_q.lcr[`LC_STICK];

  uart_rx_frame #(
    .LOW_CNT_WIDTH(8)
  ) u_rx (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .link(link)
  );

  assign src = {s_q.msr_delta != 4'h0 && s_q.interrupt_enable_mask[`IE_MODEM],
                s_q.tx_holding_empty_irq && s_q.interrupt_enable_mask[`IE_TX_EMPTY],
                s_q.rx_ready_flag && s_q.interrupt_enable_mask[`IE_RX_DATA],
                s_q.ls_irq && s_q.interrupt_enable_mask[`IE_LINE_STAT]};

  always_comb
  begin
    s_d = s_q;
    // divisor counter makes the 16x enable
    if (s_q.bcnt <= 16'h0001)
    begin
      s_d.bcnt = s_q.div;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.bcnt = s_q.bcnt - 16'h0001;
      s_d.tick = 1'b0;
    end

    // read side effects; the sets below come later and win
    if (rd && hit_rxtx && !dlab)
    begin
      s_d.rx_ready_flag = 1'b0;
    end
    if (rd && hit_lsr)
    begin
      s_d.overrun_flag = 1'b0;
      s_d.parity_err_flag = 1'b0;
      s_d.framing_err_flag = 1'b0;
      s_d.break_flag = 1'b0;
      s_d.ls_irq = 1'b0;
    end
    if (rd && hit_msr)
      s_d.msr_delta = 4'h0;
    // id read clears tx interrupt if reported
    if (rd && hit_iir && s_q.pending_interrupt_code == `ID_TX_EMPTY)
      s_d.tx_holding_empty_irq = 1'b0;

    if (wr)
    begin
      if (hit_rxtx && dlab)
      begin
        s_d.div[7:0] = cpu_wdata;
        // reload at once so a new rate needs no long wait
        s_d.bcnt = {s_q.div[15:8], cpu_wdata};
      end
      if (hit_ier && dlab)
      begin
        s_d.div[15:8] = cpu_wdata;
        s_d.bcnt = {cpu_wdata, s_q.div[7:0]};
      end
      if (hit_ier && !dlab)
        s_d.interrupt_enable_mask = cpu_wdata[3:0];
      if (hit_lcr)
        s_d.lcr = cpu_wdata;
      if (hit_lsr && !cpu_wdata[`LS_RX_READY])
        s_d.rx_ready_flag = 1'b0;
    end

    if (link.char_valid)
    begin
      s_d.rx_buffer = link.char_data;
      s_d.rx_ready_flag = 1'b1;
      if (s_q.rx_ready_flag && !(rd && hit_rxtx && !dlab))
        s_d.overrun_flag = 1'b1;
      if (link.parity_err)
        s_d.parity_err_flag = 1'b1;
      if (link.framing_err)
        s_d.framing_err_flag = 1'b1;
    end
    if (link.break_det)
      s_d.break_flag = 1'b1;
    // any error raises line status source
    if ((link.char_valid && (link.parity_err || link.framing_err
        || (s_q.rx_ready_flag && !(rd && hit_rxtx && !dlab))))
        || link.break_det)
      s_d.ls_irq = 1'b1;

    s_d.msr_prev = modem_now;
    s_d.msr_delta[0] = s_d.msr_delta[0] | (modem_now[0] ^ s_q.msr_prev[0]);
    s_d.msr_delta[1] = s_d.msr_delta[1] | (modem_now[1] ^ s_q.msr_prev[1]);
    s_d.msr_delta[2] = s_d.msr_delta[2] | (s_q.msr_prev[2] & ~modem_now[2]);
    s_d.msr_delta[3] = s_d.msr_delta[3] | (modem_now[3] ^ s_q.msr_prev[3]);

    // transmitter
    if (s_q.tick)
    begin
      s_d.tx_cnt = s_q.tx_cnt + 6'h01;
      case (s_q.tx_state)
        uart_pkg::tx_start:
          if (s_q.tx_cnt[3:0] == `TICK_LAST)
          begin
            s_d.tx_cnt = 6'h00;
            s_d.tx_bit = 3'h0;
            s_d.tx_state = uart_pkg::tx_data;
          end
        uart_pkg::tx_data:
          if (s_q.tx_cnt[3:0] == `TICK_LAST)
          begin
            s_d.tx_cnt = 6'h00;
            s_d.tx_sh = {1'b0, s_q.tx_sh[7:1]};
            s_d.tx_bit = s_q.tx_bit + 3'h1;
            if (s_q.tx_bit == 3'h4 + {1'b0, s_q.lcr[1:0]})
              s_d.tx_state = s_q.lcr[`LC_PARITY_EN] ? uart_pkg::tx_parity
                           : uart_pkg::tx_stop;
          end
        uart_pkg::tx_parity:
          if (s_q.tx_cnt[3:0] == `TICK_LAST)
          begin
            s_d.tx_cnt = 6'h00;
            s_d.tx_state = uart_pkg::tx_stop;
          end
        uart_pkg::tx_stop:
          if (s_q.tx_cnt == stop_last)
          begin
            s_d.tx_cnt = 6'h00;
            s_d.tx_state = uart_pkg::tx_idle;
          end
        default:
          s_d.tx_cnt = 6'h00;
      endcase
    end
    if (s_d.tx_state == uart_pkg::tx_idle)
      s_d.tx_shifter_empty = 1'b1;
    if (s_d.tx_state == uart_pkg::tx_idle && !s_q.tx_holding_empty)
    begin
      s_d.tx_holding_empty = 1'b1;
      s_d.tx_shifter_empty = 1'b0;
      s_d.tx_holding_empty_irq = 1'b1;
      s_d.tx_sh = s_q.tx_holding;
      s_d.tx_par = s_q.lcr[`LC_STICK] ? ~s_q.lcr[`LC_EVEN]
                 : (^(s_q.tx_holding & txmask)) ^ ~s_q.lcr[`LC_EVEN];
      s_d.tx_cnt = 6'h00;
      s_d.tx_state = uart_pkg::tx_start;
    end
    if (wr && hit_rxtx && !dlab)
    begin
      s_d.tx_holding = cpu_wdata;
      s_d.tx_holding_empty = 1'b0;
      s_d.tx_holding_empty_irq = 1'b0;
    end
    case (s_d.tx_state)
      uart_pkg::tx_start:
        s_d.sout = 1'b0;
      uart_pkg::tx_data:
        s_d.sout = s_d.tx_sh[0];
      uart_pkg::tx_parity:
        s_d.sout = s_d.tx_par;
      default:
        s_d.sout = 1'b1;
    endcase
    if (s_d.lcr[`LC_SET_BREAK])
      s_d.sout = 1'b0;

    // code frozen while the id register is addressed
    if (!(cpu_cs && hit_iir))
    begin
      if (src[0])
        s_d.pending_interrupt_code = `ID_LINE_STAT;
      else if (src[1])
        s_d.pending_interrupt_code = `ID_RX_DATA;
      else if (src[2])
        s_d.pending_interrupt_code = `ID_TX_EMPTY;
      else if (src[3])
        s_d.pending_interrupt_code = `ID_MODEM;
      else
        s_d.pending_interrupt_code = `ID_NONE;
    end
    // irq while any enabled source is active
    s_d.irq = src != 4'h0;

    if (rd)
    begin
      if (hit_rxtx)
        s_d.rdata = dlab ? s_q.div[7:0] : s_q.rx_buffer;
      else if (hit_ier)
        s_d.rdata = dlab ? s_q.div[15:8] : {4'h0, s_q.interrupt_enable_mask};
      else if (hit_iir)
        s_d.rdata = {5'h00, s_q.pending_interrupt_code};
      else if (hit_lcr)
        s_d.rdata = s_q.lcr;
      else if (hit_lsr)
        s_d.rdata = lsr_val;
      else if (hit_msr)
        s_d.rdata = {s_q.msr_prev, s_q.msr_delta};
      else
        s_d.rdata = 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.div <= `DIVISOR_RESET;
      s_q.bcnt <= `DIVISOR_RESET;
      s_q.lcr <= `LINE_CTRL_RESET;
      s_q.tx_holding_empty <= 1'b1;
      s_q.tx_shifter_empty <= 1'b1;
      s_q.tx_state <= uart_pkg::tx_idle;
      s_q.sout <= 1'b1;
      // id reads none pending after reset
      s_q.pending_interrupt_code <= `ID_NONE;
    end
    else
      s_q <= s_d;
  end

  assign cpu_rdata = s_q.rdata;
  assign irq_out = s_q.irq;
  assign baud_out = s_q.tick;
  assign sout = s_q.sout;
endmodule
`default_nettype wire

// >>> verif/line_status_checker.sv
// assertions on the serial controller's processor and line ports
`timescale 1ns/1ns
`default_nettype none
`include "uart_regs.svh"
module line_status_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cpu_cs,
  input wire logic [9:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic irq_out,
  input wire logic baud_out,
  input wire logic sin,
  input wire logic sout,
  input wire logic cts_in_n,
  input wire logic dsr_in_n,
  input wire logic ri_in_n,
  input wire logic carrier_detect_in_n
);
  logic dlab_q;
  logic [3:0] en_q;
  // shadow of the enable bits, so irq can be tied to them
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dlab_q <= 1'b0;
      en_q <= 4'h0;
    end
    else if (cpu_cs && cpu_wr && cpu_addr == `ADDR_LINE_CTRL)
    begin
      dlab_q <= cpu_wdata[7];
    end
    else if (cpu_cs && cpu_wr && cpu_addr == `ADDR_IRQ_EN && !dlab_q)
    begin
      en_q <= cpu_wdata[3:0];
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence ls_rd;
    cpu_cs && cpu_rd && cpu_addr == `ADDR_LINE_STAT;
  endsequence
  sequence id_rd;
    cpu_cs && cpu_rd && cpu_addr == `ADDR_IRQ_ID;
  endsequence

  lsr_top_zero_a: assert property (ls_rd |=> cpu_rdata[7] == 1'b0)
    else $error("line status bit 7 set");
  id_high_zero_a: assert property (id_rd |=> cpu_rdata[7:3] == 5'h00)
    else $error("id bits 7 to 3 set");
  id_code_legal_a: assert property (id_rd |=> cpu_rdata[2:0] inside
    {`ID_NONE, `ID_LINE_STAT, `ID_RX_DATA, `ID_TX_EMPTY, `ID_MODEM})
    else $error("illegal id code");
  id_freeze_a: assert property (id_rd ##1 id_rd |=> $stable(cpu_rdata))
    else $error("id code moved while addressed");
  errors_clear_a: assert property (ls_rd ##1 ls_rd |=>
    cpu_rdata[4:1] == 4'h0)
    else $error("error flags survived a status read");
  quiet_irq_a: assert property (en_q == 4'h0 |=> !irq_out)
    else $error("irq with all sources disabled");
  modem_irq_a: assert property (en_q[3] && $fell(cts_in_n)
    |-> ##[1:3] irq_out)
    else $error("modem change raised no irq");
  reset_idle_a: assert property ($rose(rst_n)
    |-> !irq_out && sout && cpu_rdata == 8'h00)
    else $error("outputs not idle after reset");
endmodule

bind uart_line_status_irq_id line_status_checker checker_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .cpu_cs(cpu_cs), .cpu_addr(cpu_addr),
  .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata),
  .cpu_rdata(cpu_rdata), .irq_out(irq_out), .baud_out(baud_out),
  .sin(sin), .sout(sout), .cts_in_n(cts_in_n), .dsr_in_n(dsr_in_n),
  .ri_in_n(ri_in_n), .carrier_detect_in_n(carrier_detect_in_n)
);
`default_nettype wire

// >>> verif/serial_terminal_model.sv
// terminal on the serial line: sends framed characters and breaks
`timescale 1ns/1ns
`default_nettype none
module serial_terminal_model (
  input wire logic sys_clk,
  input wire logic baud_out,
  input wire logic sout,
  output var logic sin
);
  logic late;
  initial sin = 1'b1;
  initial late = 1'b0;

  // bit timing follows the 16x enable; a stuck enable cannot hang the run
  task automatic wait_ticks(input int n);
    int k;
    int c;
    k = 0;
    c = 0;
    while (k < n && c < 64 * n)
    begin
      @(posedge sys_clk);
      c++;
      if (baud_out)
        k++;
    end
    if (k < n)
      late = 1'b1;
  endtask

  // one 8-bit character from the controller, each bit at its centre
  task automatic recv(output logic [7:0] d);
    int n;
    n = 0;
    while (sout && n < 4000)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (sout)
      late = 1'b1;
    wait_ticks(8);
    for (int i = 0; i < 8; i++)
    begin
      wait_ticks(16);
      d[i] = sout;
    end
  endtask

  task automatic send_bit(input logic b);
    sin <= b;
    wait_ticks(16);
  endtask

  // a bad stop is cut short so it cannot pass for a new start bit
  task automatic send(input logic [7:0] d, input int nbits, input logic pen,
    input logic pbit, input logic stop);
    send_bit(1'b0);
    for (int i = 0; i < nbits; i++)
    begin
      send_bit(d[i]);
    end
    if (pen)
      send_bit(pbit);
    sin <= stop;
    wait_ticks(stop ? 16 : 10);
    sin <= 1'b1;
    wait_ticks(16);
  endtask

  task automatic hold_low(input int bits);
    sin <= 1'b0;
    wait_ticks(16 * bits);
    sin <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> verif/uart_line_status_irq_id_bench.sv
// self-checking bench for the line status and interrupt id block
`timescale 1ns/1ns
`default_nettype none
`include "uart_regs.svh"
module uart_line_status_irq_id_bench;
  logic sys_clk, rst_n, cpu_cs, cpu_rd, cpu_wr, irq_out, baud_out, sin, sout;
  logic cts_in_n, dsr_in_n, ri_in_n, carrier_detect_in_n;
  logic [9:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata, r0, r1, d;
  logic [31:0] lfsr_q;
  int miscompares, samples_checked, g;

  uart_line_status_irq_id #(.DIV_WIDTH(16)) dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .cpu_cs(cpu_cs), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
    .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .irq_out(irq_out), .baud_out(baud_out), .sin(sin), .sout(sout),
    .cts_in_n(cts_in_n), .dsr_in_n(dsr_in_n), .ri_in_n(ri_in_n),
    .carrier_detect_in_n(carrier_detect_in_n));
  serial_terminal_model term (.sys_clk(sys_clk), .baud_out(baud_out),
    .sout(sout), .sin(sin));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // id byte expected for the highest enabled pending source
  function automatic logic [7:0] id_exp(input logic ls, rx, tx, md);
    if (ls)
      return 8'h06;
    if (rx)
      return 8'h04;
    if (tx)
      return 8'h02;
    return md ? 8'h00 : 8'h01;
  endfunction

  task automatic end_of_test();
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    cpu_cs <= 1'b1;
    cpu_wr <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= v;
    @(posedge sys_clk);
    cpu_cs <= 1'b0;
    cpu_wr <= 1'b0;
  endtask

  // n back-to-back reads; gets the last answer, r0 the one before
  task automatic rd(input logic [9:0] a, input int n);
    @(posedge sys_clk);
    cpu_cs <= 1'b1;
    cpu_rd <= 1'b1;
    cpu_addr <= a;
    for (int k = 0; k < n; k++)
    begin
      @(posedge sys_clk);
      if (k == n - 1)
      begin
        cpu_cs <= 1'b0;
        cpu_rd <= 1'b0;
      end
      #1;
      r0 = r1;
      r1 = cpu_rdata;
    end
  endtask

  task automatic set_div(input logic [15:0] dv, input logic [7:0] lc);
    wr(`ADDR_LINE_CTRL, 8'h80);
    wr(`ADDR_RX_TX, dv[7:0]);
    wr(`ADDR_IRQ_EN, dv[15:8]);
    wr(`ADDR_LINE_CTRL, lc);
  endtask

  task automatic wait_baud();
    g = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      g++;
    end
    while (!baud_out && g < 5000);
    if (!baud_out)
    begin
      miscompares++;
      end_of_test();
    end
  endtask

  task automatic wait_lsr(input logic [7:0] m);
    int n;
    n = 0;
    r1 = 8'h00;
    while ((r1 & m) !== m)
    begin
      rd(`ADDR_LINE_STAT, 1);
      n++;
      if (n > 400)
      begin
        miscompares++;
        end_of_test();
      end
    end
  endtask

  initial
  begin
    rst_n = 1'b0;
    cpu_cs = 1'b0;
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    cpu_addr = 10'h000;
    cpu_wdata = 8'h00;
    cts_in_n = 1'b1;
    dsr_in_n = 1'b1;
    ri_in_n = 1'b1;
    carrier_detect_in_n = 1'b1;
    lfsr_q = 32'hcff9;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`ADDR_LINE_STAT, 1);
    chk(r1, 8'h60);
    rd(`ADDR_IRQ_ID, 2);
    chk(r1, id_exp(0, 0, 0, 0));
    rd(10'h3fc, 1);
    chk(r1, 8'h00);
    wait_baud();
    wait_baud();
    chk(g[7:0], 8'h0c);
    set_div(16'h0003, 8'h03);
    wait_baud();
    wait_baud();
    chk(g[7:0], 8'h03);
    set_div(16'h0001, 8'h03);
    for (int i = 0; i < 4; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      term.send(lfsr_q[7:0], 8, 1'b0, 1'b0, 1'b1);
      rd(`ADDR_LINE_STAT, 1);
      chk(r1 & 8'h1f, 8'h01);
      rd(`ADDR_RX_TX, 1);
      chk(r1, lfsr_q[7:0]);
      rd(`ADDR_LINE_STAT, 1);
      chk(r1 & 8'h01, 8'h00);
    end
    term.send(8'h5a, 8, 1'b0, 1'b0, 1'b1);
    term.send(8'ha3, 8, 1'b0, 1'b0, 1'b1);
    rd(`ADDR_LINE_STAT, 2);
    chk(r0 & 8'h1f, 8'h03);
    chk(r1 & 8'h1f, 8'h01);
    wr(`ADDR_LINE_STAT, 8'h00);
    rd(`ADDR_LINE_STAT, 1);
    chk(r1 & 8'h01, 8'h00);
    rd(`ADDR_RX_TX, 1);
    chk(r1, 8'ha3);
    wr(`ADDR_IRQ_EN, 8'h0f);
    set_div(16'h0001, 8'h1b);
    lfsr_q = lfsr_next(lfsr_q);
    d = lfsr_q[7:0];
    term.send(d, 8, 1'b1, ~(^d), 1'b1);
    chk({7'h00, irq_out}, 8'h01);
    rd(`ADDR_IRQ_ID, 1);
    chk(r1, id_exp(1, 1, 0, 0));
    rd(`ADDR_LINE_STAT, 1);
    chk(r1 & 8'h1f, 8'h05);
    rd(`ADDR_IRQ_ID, 1);
    chk(r1, id_exp(0, 1, 0, 0));
    rd(`ADDR_RX_TX, 1);
    chk(r1, d);
    rd(`ADDR_IRQ_ID, 1);
    chk(r1, id_exp(0, 0, 0, 0));
    set_div(16'h0001, 8'h38);
    term.send(d, 5, 1'b1, 1'b1, 1'b1);
    rd(`ADDR_LINE_STAT, 1);
    chk(r1 & 8'h1f, 8'h05);
    rd(`ADDR_RX_TX, 1);
    chk(r1, d & 8'h1f);
    set_div(16'h0001, 8'h03);
    term.send(lfsr_q[15:8], 8, 1'b0, 1'b0, 1'b0);
    rd(`ADDR_LINE_STAT, 1);
    chk(r1 & 8'h1f, 8'h09);
    rd(`ADDR_RX_TX, 1);
    term.hold_low(12);
    rd(`ADDR_LINE_STAT, 1);
    chk(r1 & 8'h18, 8'h18);
    repeat (400) @(posedge sys_clk);
    rd(`ADDR_RX_TX, 1);
    rd(`ADDR_LINE_STAT, 1);
    wr(`ADDR_IRQ_EN, 8'h02);
    wr(`ADDR_RX_TX, lfsr_q[23:16]);
    wr(`ADDR_RX_TX, lfsr_q[31:24]);
    rd(`ADDR_LINE_STAT, 1);
    chk(r1 & 8'h60, 8'h00);
    wait_lsr(8'h60);
    chk({7'h00, irq_out}, 8'h01);
    rd(`ADDR_IRQ_ID, 2);
    chk(r0, id_exp(0, 0, 1, 0));
    chk(r1, id_exp(0, 0, 1, 0));
    rd(`ADDR_IRQ_ID, 1);
    chk(r1, id_exp(0, 0, 0, 0));
    wr(`ADDR_RX_TX, 8'h11);
    term.recv(d);
    chk(d, 8'h11);
    wait_lsr(8'h20);
    wr(`ADDR_RX_TX, 8'h22);
    rd(`ADDR_IRQ_ID, 1);
    chk(r1, id_exp(0, 0, 0, 0));
    wait_lsr(8'h60);
    wr(`ADDR_IRQ_EN, 8'h08);
    @(posedge sys_clk);
    cts_in_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk({7'h00, irq_out}, 8'h01);
    rd(`ADDR_IRQ_ID, 1);
    chk(r1, id_exp(0, 0, 0, 1));
    rd(`ADDR_MODEM_STAT, 1);
    chk(r1, 8'h11);
    repeat (3) @(posedge sys_clk);
    #1;
    chk({7'h00, irq_out}, 8'h00);
    chk({7'h00, term.late}, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
